// ===== shared/scaler_pkg.sv
package scaler_pkg;

  // parameter database
  localparam int          DB_DEPTH   = 64;
  localparam int          DB_AW      = 6;
  localparam int          DB_W       = 24;

  // region and register addresses
  localparam logic [15:0] MIRROR_BASE      = 16'h03E8;
  localparam logic [15:0] MIRROR_END       = 16'h07D0;
  localparam logic [15:0] ADDR_INPUT_TYPE  = 16'h0FD1;
  localparam logic [15:0] ADDR_TEMP_PLACES = 16'h0FE4;
  localparam logic [15:0] ADDR_LIN_PLACES  = 16'h0FE5;
  localparam logic [15:0] ADDR_DERIV_RATE  = 16'h000B;
  localparam logic [15:0] ADDR_ALARM1_SP   = 16'h0024;

  // register limits and reset values
  localparam logic [15:0] LIN_PLACES_MAX   = 16'h0003;
  localparam logic [15:0] TEMP_PLACES_MAX  = 16'h0001;
  localparam logic [15:0] PLACES_RESET     = 16'h0000;
  localparam logic [15:0] INPUT_TYPE_RESET = 16'h0000;
  // input type codes from here upward count as linear inputs
  localparam logic [15:0] LINEAR_TYPE_MIN  = 16'h0010;

  // scaling
  localparam logic signed [31:0] SCALE_TEN = 32'sh0000000A;
  localparam logic signed [31:0] HALF_TEN  = 32'sh00000005;
  localparam logic signed [31:0] S16_MAX   = 32'sh00007FFF;
  localparam logic signed [31:0] S16_MIN   = -32'sh00008000;

  // function codes
  localparam logic [7:0]  FC_READ       = 8'h03;
  localparam logic [7:0]  FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0]  FC_WRITE_MANY = 8'h10;

  // exception codes
  localparam logic [7:0]  EXC_NONE = 8'h00;
  localparam logic [7:0]  EXC_FUNC = 8'h01;
  localparam logic [7:0]  EXC_ADDR = 8'h02;

  typedef enum logic [1:0] {
    PT_INTEGER     = 2'b00,
    PT_WITH_POINT  = 2'b01,   // stored_with_point_type
    PT_INPUT_DEP   = 2'b10    // input_dependent_storage_type
  } param_type_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
  } req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic [7:0]  exc;
  } rsp_t;

  typedef struct packed {
    logic [DB_DEPTH-1:0][DB_W-1:0] db;
    logic [15:0]                   temp_places;
    logic [15:0]                   lin_places;
    logic [15:0]                   input_type;
    logic [1:0]                    active_places;
    rsp_t                          rsp;
  } state_t;

endpackage : scaler_pkg

// ===== logic/fractional_value_register_scaler.sv
// Operation
// - with-point parameters keep value with fraction
// - base region rounds with-point values to integer
// - fraction .1-.4 rounds down, .5-.9 up
// - input-dependent linear values stored as scaled integer
// - scaled integers use decimal-position setting for point; the block only reports it on o_active_places and never applies it
// - linear decimal-position setting at address 4069
// - temperature inputs allow at most one place
// - linear inputs allow at most three places
// - decimal-position setting resets to zero places
// - mirror read returns ten times value, rounded
// - mirror address maps to base address minus 1000
// - mirror read saturates to signed 16-bit limits
// - read code 03, write codes 06 and 16
// - mirror write stores written value divided by ten
// - temperature decimal-places setting at address 4068
`timescale 1ns/1ps
module fractional_value_register_scaler (
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset_n,
  input  wire scaler_pkg::req_t     i_req,
  output scaler_pkg::rsp_t          o_rsp,
  output logic [1:0]                o_active_places
);
  import scaler_pkg::*;

  state_t st_r;
  state_t st_nxt;

  // which stored parameters carry fractions; the rest are plain integers
  function automatic param_type_t type_of(input logic [15:0] a);
    case (a)
      ADDR_DERIV_RATE: type_of = PT_WITH_POINT;
      ADDR_ALARM1_SP:  type_of = PT_INPUT_DEP;
      default:         type_of = PT_INTEGER;
    endcase
  endfunction : type_of

  // tenths to nearest whole, half away from zero
  function automatic logic signed [31:0] round_tenths(input logic signed [31:0] t);
    logic signed [31:0] mag;
    logic signed [31:0] q;
    mag = (t < 0) ? -t : t;
    q = (mag + HALF_TEN) / SCALE_TEN;
    round_tenths = (t < 0) ? -q : q;
  endfunction : round_tenths

  function automatic logic [15:0] sat16(input logic signed [31:0] v);
    if (v > S16_MAX) begin
      sat16 = S16_MAX[15:0];
    end else if (v < S16_MIN) begin
      sat16 = S16_MIN[15:0];
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  logic               is_read;
  logic               is_write;
  logic               in_mirror;
  logic               in_base;
  logic [15:0]        base_addr;
  logic [DB_AW-1:0]   idx;
  param_type_t        ptype;
  logic               linear_in;
  logic               point_kept;
  logic signed [31:0] stored;
  logic signed [31:0] wr_val;
  logic [15:0]        rd_val;
  logic [15:0]        lin_wr;
  logic [15:0]        temp_wr;

  always_comb begin
    is_read   = i_req.func == FC_READ;
    is_write  = (i_req.func == FC_WRITE_ONE) || (i_req.func == FC_WRITE_MANY);
    in_mirror = (i_req.addr >= MIRROR_BASE) && (i_req.addr < MIRROR_END);
    base_addr = in_mirror ? i_req.addr - MIRROR_BASE : i_req.addr;
    in_base   = base_addr < 16'(DB_DEPTH);
    idx       = base_addr[DB_AW-1:0];
    ptype     = type_of(base_addr);
    linear_in = st_r.input_type >= LINEAR_TYPE_MIN;
    // with-point values are held in tenths, whatever the input
    point_kept = (ptype == PT_WITH_POINT) || (ptype == PT_INPUT_DEP && !linear_in);
    stored    = 32'(signed'(st_r.db[idx]));
    wr_val    = 32'(signed'(i_req.data));
    lin_wr    = (i_req.data > LIN_PLACES_MAX) ? LIN_PLACES_MAX : i_req.data;
    temp_wr   = (i_req.data > TEMP_PLACES_MAX) ? TEMP_PLACES_MAX : i_req.data;
    rd_val    = 16'h0000;
    if (in_mirror) begin
      // plain integers have no mirror; tenths already are ten times the value
      rd_val = point_kept ? sat16(stored) : sat16(stored * SCALE_TEN);
    end else if (point_kept) begin
      rd_val = sat16(round_tenths(stored));
    end else begin
      rd_val = stored[15:0];
    end

    st_nxt           = st_r;
    st_nxt.rsp.valid = i_req.valid;
    st_nxt.rsp.data  = 16'h0000;
    st_nxt.rsp.exc   = EXC_NONE;
    // the point position for scaled integers; the block only reports it on o_active_places and never applies it
    st_nxt.active_places = linear_in ? st_r.lin_places[1:0] : st_r.temp_places[1:0];
    if (i_req.valid) begin
      if (!is_read && !is_write) begin
        st_nxt.rsp.exc = EXC_FUNC;
      end else if (!in_mirror && i_req.addr == ADDR_LIN_PLACES) begin
        if (is_write) begin
          st_nxt.lin_places = lin_wr;
        end
        st_nxt.rsp.data = is_write ? lin_wr : st_r.lin_places;
      end else if (!in_mirror && i_req.addr == ADDR_TEMP_PLACES) begin
        if (is_write) begin
          st_nxt.temp_places = temp_wr;
        end
        st_nxt.rsp.data = is_write ? temp_wr : st_r.temp_places;
      end else if (!in_mirror && i_req.addr == ADDR_INPUT_TYPE) begin
        if (is_write) begin
          st_nxt.input_type = i_req.data;
        end
        st_nxt.rsp.data = is_write ? i_req.data : st_r.input_type;
      end else if (!in_base || (in_mirror && ptype == PT_INTEGER)) begin
        st_nxt.rsp.exc = EXC_ADDR;
      end else if (is_read) begin
        st_nxt.rsp.data = rd_val;
      end else begin
        st_nxt.rsp.data = i_req.data;
        if (in_mirror && point_kept) begin
          // tenths: the written number already is the stored form
          st_nxt.db[idx] = DB_W'(wr_val);
        end else if (in_mirror) begin
          st_nxt.db[idx] = DB_W'(wr_val / SCALE_TEN);
        end else if (point_kept) begin
          st_nxt.db[idx] = DB_W'(wr_val * SCALE_TEN);
        end else begin
          st_nxt.db[idx] = DB_W'(wr_val);
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      st_r             <= '0;
      st_r.lin_places  <= PLACES_RESET;
      st_r.temp_places <= PLACES_RESET;
      st_r.input_type  <= INPUT_TYPE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rsp           = st_r.rsp;
  assign o_active_places = st_r.active_places;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  rsp_follows_req_a: assert property (i_req.valid |=> o_rsp.valid)
    else $error("request without response");
  no_idle_rsp_a: assert property (!i_req.valid |=> !o_rsp.valid)
    else $error("response without request");
  bad_func_exc_a: assert property (i_req.valid && !is_read && !is_write
      |=> o_rsp.exc == EXC_FUNC)
    else $error("unknown function not refused");
  lin_places_cap_a: assert property (st_r.lin_places <= LIN_PLACES_MAX)
    else $error("linear places above three");
  temp_places_cap_a: assert property (st_r.temp_places <= TEMP_PLACES_MAX)
    else $error("temperature places above one");
  places_reset_a: assert property (disable iff (1'b0) !i_reset_n
      |=> st_r.lin_places == PLACES_RESET && st_r.temp_places == PLACES_RESET)
    else $error("places not zero after reset");
  base_round_a: assert property (i_req.valid && is_read && !in_mirror && in_base
      && point_kept |=> o_rsp.data == sat16(round_tenths($past(stored))))
    else $error("base read not rounded");
  mirror_sat_a: assert property (i_req.valid && is_read && in_mirror && !point_kept
      && ptype != PT_INTEGER && stored * SCALE_TEN > S16_MAX
      |=> o_rsp.data == S16_MAX[15:0])
    else $error("mirror read not saturated");
  mirror_write_a: assert property (i_req.valid && is_write && in_mirror && in_base
      && ptype != PT_INTEGER && !point_kept
      |=> 32'(signed'(st_r.db[$past(idx)])) == $past(wr_val) / SCALE_TEN)
    else $error("mirror write not divided by ten");
  base_point_write_a: assert property (i_req.valid && is_write && !in_mirror
      && in_base && point_kept
      |=> 32'(signed'(st_r.db[$past(idx)])) == $past(wr_val) * SCALE_TEN)
    else $error("base write not kept in tenths");
  // refusals leave the database alone
  mirror_int_refuse_a: assert property (i_req.valid && (is_read || is_write)
      && in_mirror && ptype == PT_INTEGER
      |=> o_rsp.exc == EXC_ADDR && $stable(st_r.db))
    else $error("integer mirror address not refused");
  bad_func_keeps_a: assert property (i_req.valid && !is_read && !is_write
      |=> $stable(st_r.db))
    else $error("refused function changed a parameter");
  exc_data_zero_a: assert property (o_rsp.valid && o_rsp.exc != EXC_NONE
      |-> o_rsp.data == 16'h0000)
    else $error("refused request returned data");
  mirror_point_read_a: assert property (i_req.valid && is_read && in_mirror
      && point_kept |=> o_rsp.data == sat16($past(stored)))
    else $error("mirror read not in tenths");
  base_scaled_write_a: assert property (i_req.valid && is_write && !in_mirror
      && in_base && !point_kept
      |=> 32'(signed'(st_r.db[$past(idx)])) == $past(wr_val))
    else $error("scaled value not stored as written");
  // one cycle of lag between the places registers and the output
  lin_active_a: assert property (linear_in
      |=> {14'h0000, o_active_places} == $past(st_r.lin_places))
    else $error("linear places not applied");
  temp_active_a: assert property (!linear_in
      |=> {14'h0000, o_active_places} == $past(st_r.temp_places))
    else $error("temperature places not applied");
  lin_place_write_a: assert property (i_req.valid && is_write
      && i_req.addr == ADDR_LIN_PLACES |=> st_r.lin_places
      == (($past(i_req.data) > LIN_PLACES_MAX) ? LIN_PLACES_MAX : $past(i_req.data)))
    else $error("linear places write lost");
  temp_place_write_a: assert property (i_req.valid && is_write
      && i_req.addr == ADDR_TEMP_PLACES |=> st_r.temp_places
      == (($past(i_req.data) > TEMP_PLACES_MAX) ? TEMP_PLACES_MAX : $past(i_req.data)))
    else $error("temperature places write lost");

endmodule : fractional_value_register_scaler

// ===== verif/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  input  wire scaler_pkg::rsp_t i_rsp,
  input  wire logic             i_mclk,
  output scaler_pkg::req_t      o_req
);
  import scaler_pkg::*;

  initial o_req = '0;

  // one request per call; lines are driven off the falling edge
  task automatic xfer(input logic [7:0] func, input logic [15:0] addr,
                      input logic [15:0] data, output rsp_t rsp, output logic ok);
    ok = 1'b0;
    rsp = '0;
    @(negedge i_mclk);
    o_req = '{valid: 1'b1, func: func, addr: addr, data: data};
    for (int n = 0; n < 4; n++) begin
      @(negedge i_mclk);
      o_req.valid = 1'b0;
      // released lines flip so a stale value never looks fresh
      o_req.addr = ~addr;
      o_req.data = ~data;
      if (i_rsp.valid === 1'b1) begin
        rsp = i_rsp;
        ok = 1'b1;
        break;
      end
    end
  endtask : xfer
endmodule : bus_master_model

// ===== verif/tb_fractional_value_register_scaler.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_fractional_value_register_scaler;
  import scaler_pkg::*;
  logic       i_mclk;
  logic       i_reset_n;
  req_t       i_req;
  rsp_t       o_rsp;
  logic [1:0] o_active_places;
  int         fails = 0;
  int         num_checks = 0;
  logic [15:0] tenths [7] = '{16'h0011, 16'h000E, 16'h000F, 16'h000B, 16'h0013,
                              16'hFFE7, 16'hFFF2};
  logic [15:0] whole  [7] = '{16'h0002, 16'h0001, 16'h0002, 16'h0001, 16'h0002,
                              16'hFFFD, 16'hFFFF};

  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  fractional_value_register_scaler DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_req(i_req), .o_rsp(o_rsp), .o_active_places(o_active_places));
  bus_master_model master (.i_rsp(o_rsp), .i_mclk(i_mclk), .o_req(i_req));

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic acc(input logic [7:0] func, input logic [15:0] addr,
                     input logic [15:0] data, output rsp_t r);
    logic ok;
    master.xfer(func, addr, data, r, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      tally_and_finish();
    end
  endtask : acc

  task automatic wr(input logic [7:0] func, input logic [15:0] addr, input logic [15:0] d);
    rsp_t r;
    acc(func, addr, d, r);
    `CHK(r.exc, EXC_NONE)
  endtask : wr

  task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
    rsp_t r;
    acc(FC_READ, addr, 16'h0000, r);
    `CHK(r.exc, EXC_NONE)
    `CHK(r.data, exp)
  endtask : rd

  task automatic refused(input logic [7:0] func, input logic [15:0] addr,
                         input logic [7:0] exc);
    rsp_t r;
    acc(func, addr, 16'h0001, r);
    `CHK(r.exc, exc)
    `CHK(r.data, 16'h0000)
  endtask : refused

  initial begin
    i_reset_n = 1'b0;
    repeat (10) @(negedge i_mclk);
    i_reset_n = 1'b1;
    rd(ADDR_LIN_PLACES, PLACES_RESET);
    rd(ADDR_TEMP_PLACES, PLACES_RESET);
    `CHK(o_active_places, 2'h0)
    $display("test reset_values done");
    wr(FC_WRITE_ONE, ADDR_DERIV_RATE, 16'h0002);
    rd(ADDR_DERIV_RATE, 16'h0002);
    rd(ADDR_DERIV_RATE + MIRROR_BASE, 16'h0014);
    $display("test base_write done");
    // mirror writes set tenths, base reads show the rounded integer
    for (int i = 0; i < 7; i++) begin
      wr(FC_WRITE_ONE, ADDR_DERIV_RATE + MIRROR_BASE, tenths[i]);
      rd(ADDR_DERIV_RATE, whole[i]);
      rd(ADDR_DERIV_RATE + MIRROR_BASE, tenths[i]);
    end
    wr(FC_WRITE_MANY, ADDR_ALARM1_SP + MIRROR_BASE, 16'h05E1);
    rd(ADDR_ALARM1_SP, 16'h0097);
    $display("test rounding done");
    wr(FC_WRITE_ONE, ADDR_INPUT_TYPE, LINEAR_TYPE_MIN);
    wr(FC_WRITE_MANY, ADDR_LIN_PLACES, 16'h0005);
    rd(ADDR_LIN_PLACES, LIN_PLACES_MAX);
    `CHK(o_active_places, 2'h3)
    wr(FC_WRITE_MANY, ADDR_ALARM1_SP, 16'h2567);
    rd(ADDR_ALARM1_SP, 16'h2567);
    rd(ADDR_LIN_PLACES, LIN_PLACES_MAX);
    // mirror use on a linear value is deliberate here, to reach the clip
    rd(ADDR_ALARM1_SP + MIRROR_BASE, 16'h7FFF);
    wr(FC_WRITE_ONE, ADDR_ALARM1_SP, 16'hF060);
    rd(ADDR_ALARM1_SP + MIRROR_BASE, 16'h8000);
    // 4005 over ten truncates to 400
    wr(FC_WRITE_ONE, ADDR_ALARM1_SP + MIRROR_BASE, 16'h0FA5);
    rd(ADDR_ALARM1_SP, 16'h0190);
    $display("test linear done");
    wr(FC_WRITE_ONE, ADDR_TEMP_PLACES, 16'h0002);
    rd(ADDR_TEMP_PLACES, TEMP_PLACES_MAX);
    wr(FC_WRITE_ONE, ADDR_INPUT_TYPE, INPUT_TYPE_RESET);
    // the places output lags the input type write by one cycle
    @(negedge i_mclk);
    `CHK(o_active_places, 2'h1)
    $display("test temperature done");
    refused(8'h04, ADDR_DERIV_RATE, EXC_FUNC);
    refused(FC_READ, MIRROR_BASE, EXC_ADDR);
    refused(FC_READ, 16'h01F4, EXC_ADDR);
    rd(ADDR_DERIV_RATE, 16'hFFFF);
    $display("test refusals done");
    tally_and_finish();
  end
endmodule : tb_fractional_value_register_scaler
